// file: design/gpio_pkg.sv
package gpio_pkg;
	localparam int NUM_PORTS = 8;
	localparam logic [7:0] NUM_PORTS_B = 8'h08;
	// Per-port register kinds, index = kind * 8 + port
	localparam logic [1:0] KIND_DATA = 2'h0;
	localparam logic [1:0] KIND_DIR = 2'h1;
	localparam logic [1:0] KIND_PULL = 2'h2;
	// Further register addresses
	localparam logic [7:0] ADDR_WAKEUP = 8'h18;
	localparam logic [7:0] ADDR_DRIVE0 = 8'h19;
	localparam logic [7:0] ADDR_LAST_PORT_REG = 8'h17;
	// Reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam logic [7:0] WAKE_RST = 8'h00;
	localparam logic [7:0] DRIVE_RST = 8'h00;
	// Implemented pin masks, ports A..H
	localparam logic [7:0] MASK_A = 8'hff;
	localparam logic [7:0] MASK_B = 8'hff;
	localparam logic [7:0] MASK_C = 8'hff;
	localparam logic [7:0] MASK_D = 8'h7f;
	localparam logic [7:0] MASK_E = 8'h1f;
	localparam logic [7:0] MASK_F = 8'hff;
	localparam logic [7:0] MASK_G = 8'hff;
	localparam logic [7:0] MASK_H = 8'h3f;
	localparam logic [63:0] PORT_MASKS = {MASK_H, MASK_G, MASK_F, MASK_E, MASK_D, MASK_C, MASK_B, MASK_A};
	// Drive level field positions
	localparam int DRV_PA_LO = 0;
	localparam int DRV_PA_HI = 2;
	localparam int DRV_PB_LO = 4;
	localparam int DRV_PB_HI = 6;
	// Read timing: pin sampled in second phase, data returned after
	localparam logic [1:0] RD_LATENCY = 2'h2;

	typedef enum logic [2:0] {
		GP_IDLE = 3'b001,
		GP_PH2 = 3'b010,
		GP_DONE = 3'b100
	} gp_rd_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gp_req_s;
endpackage

// file: design/gp_ports.sv
module gp_ports #(
	parameter int NPORTS = gpio_pkg::NUM_PORTS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire gpio_pkg::gp_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic [63:0] pin_in,
	output logic [63:0] pin_out,
	output logic [63:0] pin_oe_n,
	output logic [63:0] pull_on,
	input wire logic [63:0] gpio_func,
	input wire logic [63:0] nmos_mode,
	input wire logic power_down,
	output logic wake,
	output logic [7:0] drive_level_select_0
);
	logic [63:0] data_q;
	logic [63:0] dir_q;
	logic [63:0] pull_q;
	logic [7:0] porta_wakeup_bits_q;
	logic [7:0] drv_q;
	logic [7:0] pa_prev_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic [7:0] rd_addr_q;
	gpio_pkg::gp_rd_e rd_st_q;
	logic [63:0] pull_d;
	logic [7:0] wake_hits;
	localparam logic [63:0] PORT_ALL = gpio_pkg::PORT_MASKS;

	function automatic logic [7:0] port_mask(input logic [2:0] p);
		port_mask = gpio_pkg::PORT_MASKS[p*8 +: 8];
	endfunction

	function automatic logic is_port_reg(input logic [7:0] a);
		is_port_reg = (a <= gpio_pkg::ADDR_LAST_PORT_REG);
	endfunction

	// Port data, direction and pull-high registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_q <= {8{gpio_pkg::DATA_RST}};
			dir_q <= {8{gpio_pkg::DIR_RST}};
			pull_q <= {8{gpio_pkg::PULL_RST}};
		end else if (req.wr && is_port_reg(req.addr)) begin
			case (req.addr[4:3])
				gpio_pkg::KIND_DATA: data_q[req.addr[2:0]*8 +: 8] <= req.wdata & port_mask(req.addr[2:0]);
				gpio_pkg::KIND_DIR: dir_q[req.addr[2:0]*8 +: 8] <= (req.wdata | ~port_mask(req.addr[2:0]));
				gpio_pkg::KIND_PULL: pull_q[req.addr[2:0]*8 +: 8] <= req.wdata & port_mask(req.addr[2:0]);
				default: data_q <= data_q;
			endcase
		end
	end

	// Wake-up enables and drive select
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			porta_wakeup_bits_q <= gpio_pkg::WAKE_RST;
			drv_q <= gpio_pkg::DRIVE_RST;
		end else if (req.wr) begin
			if (req.addr == gpio_pkg::ADDR_WAKEUP) begin
				porta_wakeup_bits_q <= req.wdata;
			end
			if (req.addr == gpio_pkg::ADDR_DRIVE0) begin
				drv_q <= req.wdata;
			end
		end
	end

	// Read sequencer: request, sample in second phase, answer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_st_q <= gpio_pkg::GP_IDLE;
			rd_addr_q <= 8'h00;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= 1'b0;
			case (rd_st_q)
				gpio_pkg::GP_IDLE: begin
					if (req.rd) begin
						rd_addr_q <= req.addr;
						rd_st_q <= gpio_pkg::GP_PH2;
					end
				end
				gpio_pkg::GP_PH2: begin
					rvalid_q <= 1'b1;
					rd_st_q <= gpio_pkg::GP_IDLE;
					if (is_port_reg(rd_addr_q)) begin
						case (rd_addr_q[4:3])
							gpio_pkg::KIND_DATA: rdata_q <= ((pin_in[rd_addr_q[2:0]*8 +: 8] & dir_q[rd_addr_q[2:0]*8 +: 8])
								| (data_q[rd_addr_q[2:0]*8 +: 8] & ~dir_q[rd_addr_q[2:0]*8 +: 8]))
								& port_mask(rd_addr_q[2:0]);
							gpio_pkg::KIND_DIR: rdata_q <= dir_q[rd_addr_q[2:0]*8 +: 8] & port_mask(rd_addr_q[2:0]);
							gpio_pkg::KIND_PULL: rdata_q <= pull_q[rd_addr_q[2:0]*8 +: 8];
							default: rdata_q <= 8'h00;
						endcase
					end else if (rd_addr_q == gpio_pkg::ADDR_WAKEUP) begin
						rdata_q <= porta_wakeup_bits_q;
					end else if (rd_addr_q == gpio_pkg::ADDR_DRIVE0) begin
						rdata_q <= drv_q;
					end else begin
						rdata_q <= 8'h00;
					end
				end
				default: rd_st_q <= gpio_pkg::GP_IDLE;
			endcase
		end
	end

	// Pin drive and pull-high gating
	always_comb begin
		pull_d = pull_q & (dir_q | nmos_mode) & PORT_ALL;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_out <= 64'h0000_0000_0000_0000;
			pin_oe_n <= 64'hffff_ffff_ffff_ffff;
			pull_on <= 64'h0000_0000_0000_0000;
		end else begin
			pin_out <= data_q;
			pin_oe_n <= dir_q | ~PORT_ALL;
			pull_on <= pull_d;
		end
	end

	// Port A falling-edge wake-up
	assign wake_hits = pa_prev_q & ~pin_in[7:0] & porta_wakeup_bits_q & gpio_func[7:0];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pa_prev_q <= 8'h00;
			wake <= 1'b0;
		end else begin
			pa_prev_q <= pin_in[7:0];
			wake <= power_down && (wake_hits != 8'h00);
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign drive_level_select_0 = drv_q;

	property p_dir_reset_input;
		@(posedge clk) $rose(rstn) |-> pin_oe_n == 64'hffff_ffff_ffff_ffff;
	endproperty
	a_dir_reset_input: assert property (p_dir_reset_input) else $error("pins not inputs after reset");

	sequence s_rd_req;
		req.rd && rd_st_q == gpio_pkg::GP_IDLE;
	endsequence
	property p_rd_latency;
		@(posedge clk) disable iff (!rstn) s_rd_req |-> ##2 rvalid;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read answer late");

	property p_unimpl_zero;
		@(posedge clk) disable iff (!rstn) rvalid && $past(rd_addr_q, 1) == 8'h04 |-> rdata[7:5] == 3'b000;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

	property p_latch_holds;
		@(posedge clk) disable iff (!rstn) !$past(req.wr) |-> $stable(data_q);
	endproperty
	a_latch_holds: assert property (p_latch_holds) else $error("output latch changed without write");

	property p_pull_off_output;
		@(posedge clk) disable iff (!rstn) (~$past(dir_q) & ~$past(nmos_mode) & pull_on) == 64'h0;
	endproperty
	a_pull_off_output: assert property (p_pull_off_output) else $error("pull-high on driven output");

	property p_wake_only_pd;
		@(posedge clk) disable iff (!rstn) wake |-> $past(power_down);
	endproperty
	a_wake_only_pd: assert property (p_wake_only_pd) else $error("wake outside power-down");

	property p_wake_fires;
		@(posedge clk) disable iff (!rstn) power_down && wake_hits != 8'h00 |=> wake;
	endproperty
	a_wake_fires: assert property (p_wake_fires) else $error("wake edge missed");

	property p_out_read_latch;
		@(posedge clk) disable iff (!rstn) rd_st_q == gpio_pkg::GP_PH2 && rd_addr_q == 8'h00 && dir_q[7:0] == 8'h00
			|=> rdata == $past(data_q[7:0]);
	endproperty
	a_out_read_latch: assert property (p_out_read_latch) else $error("output read not latch");

	property p_reset_quiet;
		@(posedge clk) $rose(rstn) |-> pull_on == 64'h0 && pin_out == 64'h0 && !rvalid && !wake;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");

	property p_wake_reg_reset;
		@(posedge clk) $rose(rstn) |-> porta_wakeup_bits_q == gpio_pkg::WAKE_RST;
	endproperty
	a_wake_reg_reset: assert property (p_wake_reg_reset) else $error("wake enables not cleared");

	property p_drive_reset;
		@(posedge clk) $rose(rstn) |-> drive_level_select_0 == gpio_pkg::DRIVE_RST;
	endproperty
	a_drive_reset: assert property (p_drive_reset) else $error("drive select not cleared");

	property p_pin_out_follows;
		@(posedge clk) disable iff (!rstn) pin_out == $past(data_q);
	endproperty
	a_pin_out_follows: assert property (p_pin_out_follows) else $error("pin drive differs from latch");

	property p_oe_follows_dir;
		@(posedge clk) disable iff (!rstn) pin_oe_n == ($past(dir_q) | ~PORT_ALL);
	endproperty
	a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("output enable differs from direction");

	property p_unimpl_clear;
		@(posedge clk) disable iff (!rstn) ((data_q | pull_q) & ~PORT_ALL) == 64'h0;
	endproperty
	a_unimpl_clear: assert property (p_unimpl_clear) else $error("unimplemented bit stored");

	property p_unimpl_dir_input;
		@(posedge clk) disable iff (!rstn) (dir_q | PORT_ALL) == 64'hffff_ffff_ffff_ffff;
	endproperty
	a_unimpl_dir_input: assert property (p_unimpl_dir_input) else $error("unimplemented direction changed");

	property p_rvalid_pulse;
		@(posedge clk) disable iff (!rstn) rvalid |=> !rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid longer than one cycle");

	property p_ph2_answers;
		@(posedge clk) disable iff (!rstn) rd_st_q == gpio_pkg::GP_PH2 |=> rvalid && rd_st_q == gpio_pkg::GP_IDLE;
	endproperty
	a_ph2_answers: assert property (p_ph2_answers) else $error("second phase gave no answer");

	sequence s_porta_input_read;
		rd_st_q == gpio_pkg::GP_PH2 && rd_addr_q == 8'h00 && dir_q[7:0] == 8'hff;
	endsequence
	property p_rd_input_pin;
		@(posedge clk) disable iff (!rstn) s_porta_input_read |=> rdata == $past(pin_in[7:0]);
	endproperty
	a_rd_input_pin: assert property (p_rd_input_pin) else $error("input read not pin sample");

	property p_unimpl_d;
		@(posedge clk) disable iff (!rstn) rvalid && $past(rd_addr_q) == 8'h03 |-> rdata[7] == 1'b0;
	endproperty
	a_unimpl_d: assert property (p_unimpl_d) else $error("port D top bit nonzero");

	property p_unimpl_h_dir;
		@(posedge clk) disable iff (!rstn) rvalid && $past(rd_addr_q) == 8'h0f |-> rdata[7:6] == 2'b00;
	endproperty
	a_unimpl_h_dir: assert property (p_unimpl_h_dir) else $error("port H direction top bits nonzero");

	property p_wake_rd;
		@(posedge clk) disable iff (!rstn) rvalid && $past(rd_addr_q) == gpio_pkg::ADDR_WAKEUP
			|-> rdata == $past(porta_wakeup_bits_q);
	endproperty
	a_wake_rd: assert property (p_wake_rd) else $error("wake enable read wrong");

	property p_drive_rd;
		@(posedge clk) disable iff (!rstn) rvalid && $past(rd_addr_q) == gpio_pkg::ADDR_DRIVE0
			|-> rdata == $past(drv_q);
	endproperty
	a_drive_rd: assert property (p_drive_rd) else $error("drive select read wrong");

	property p_wake_needs_enable;
		@(posedge clk) disable iff (!rstn) wake
			|-> ($past(porta_wakeup_bits_q) & $past(gpio_func[7:0])) != 8'h00;
	endproperty
	a_wake_needs_enable: assert property (p_wake_needs_enable) else $error("wake without enabled gpio pin");

	property p_wake_falling;
		@(posedge clk) disable iff (!rstn) wake |-> ($past(pa_prev_q) & ~$past(pin_in[7:0])) != 8'h00;
	endproperty
	a_wake_falling: assert property (p_wake_falling) else $error("wake without falling edge");

	property p_drive_write;
		@(posedge clk) disable iff (!rstn) req.wr && req.addr == gpio_pkg::ADDR_DRIVE0
			|=> drive_level_select_0 == $past(req.wdata);
	endproperty
	a_drive_write: assert property (p_drive_write) else $error("drive select write lost");

	property p_wake_write;
		@(posedge clk) disable iff (!rstn) req.wr && req.addr == gpio_pkg::ADDR_WAKEUP
			|=> porta_wakeup_bits_q == $past(req.wdata);
	endproperty
	a_wake_write: assert property (p_wake_write) else $error("wake enable write lost");

	sequence s_wr_porta_data;
		req.wr && req.addr == 8'h00;
	endsequence
	sequence s_porta_driven;
		data_q[7:0] == $past(req.wdata) ##1 pin_out[7:0] == $past(req.wdata, 2);
	endsequence
	property p_porta_write;
		@(posedge clk) disable iff (!rstn) s_wr_porta_data |=> s_porta_driven;
	endproperty
	a_porta_write: assert property (p_porta_write) else $error("port A write not driven");

	property p_pull_input_on;
		@(posedge clk) disable iff (!rstn) ($past(pull_q) & $past(dir_q) & PORT_ALL & ~pull_on) == 64'h0;
	endproperty
	a_pull_input_on: assert property (p_pull_input_on) else $error("enabled input pull-high off");

	property p_pull_needs_bit;
		@(posedge clk) disable iff (!rstn) (pull_on & ~$past(pull_q)) == 64'h0;
	endproperty
	a_pull_needs_bit: assert property (p_pull_needs_bit) else $error("pull-high on without enable");

	property p_dir_write;
		@(posedge clk) disable iff (!rstn) req.wr && req.addr == 8'h08 |=> dir_q[7:0] == $past(req.wdata);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");
endmodule // gp_ports

// file: tb/gp_pins.sv
module gp_pins (
	input wire logic clk,
	input wire logic [63:0] pin_out,
	input wire logic [63:0] pin_oe_n,
	input wire logic [63:0] pull_on,
	input wire logic [63:0] ext,
	input wire logic [63:0] ext_en,
	output logic [63:0] pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] last_q;
	// Strong board drivers win, floating pins flip every cycle
	always_ff @(posedge clk) last_q <= pin_in;
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			if (ext_en[i]) pin_in[i] = ext[i];
			else if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
			else if (pull_on[i]) pin_in[i] = 1'b1;
			else pin_in[i] = ~last_q[i];
		end
	end
endmodule // gp_pins

// file: tb/gp_ports_tb.sv
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("unexpected %0t: %h %h", $time, a, b); end end
module gp_ports_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0;
	logic rstn = 0;
	gpio_pkg::gp_req_s req = '0;
	logic [7:0] rdata, drv_sel, m, rexp, drv = 0, wk = 0;
	logic rvalid, wake, pd = 0;
	logic [63:0] pin_in, pin_out, pin_oe_n, pull_on, ext = 0, en = '1, gf = '1, nm = 0;
	logic [7:0] dat[8], dir[8], pul[8];
	logic [7:0] q[$];
	int fails = 0, total_checks = 0, wakes = 0, cyc = 0, w0;
	gp_ports u_gp_ports (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_on(pull_on), .gpio_func(gf), .nmos_mode(nm),
		.power_down(pd), .wake(wake), .drive_level_select_0(drv_sel));
	gp_pins u_gp_pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_on(pull_on), .ext(ext),
		.ext_en(en), .pin_in(pin_in));
	always #12.5 clk = ~clk;
	task stop_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		logic [2:0] p;
		p = a[2:0];
		if (a < 8'h08) return ((dat[p] & ~dir[p]) | (ext[8*p +: 8] & dir[p])) & gpio_pkg::PORT_MASKS[8*p +: 8];
		if (a < 8'h10) return dir[p];
		if (a < 8'h18) return pul[p];
		if (a == gpio_pkg::ADDR_WAKEUP) return wk;
		if (a == gpio_pkg::ADDR_DRIVE0) return drv;
		return 8'h00;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] mk;
		mk = gpio_pkg::PORT_MASKS[8*a[2:0] +: 8];
		if (a < 8'h08) dat[a[2:0]] = d & mk;
		else if (a < 8'h10) dir[a[2:0]] = d & mk;
		else if (a < 8'h18) pul[a[2:0]] = d & mk;
		else if (a == gpio_pkg::ADDR_WAKEUP) wk = d;
		else if (a == gpio_pkg::ADDR_DRIVE0) drv = d;
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		q.push_back(exp_rd(a));
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask
	task automatic fall(input logic p, input logic g, input int n);
		ext[7:0] <= 8'hff;
		pd <= p;
		gf[3] <= g;
		repeat (3) @(posedge clk);
		w0 = wakes;
		ext[7:0] <= 8'he7;
		repeat (4) @(posedge clk);
		`CHK(wakes - w0, n)
	endtask
	always @(posedge clk) begin
		cyc++;
		if (wake === 1'b1) wakes++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	always @(posedge clk) begin
		if (rvalid === 1'b1) begin
			if (q.size() == 0) begin
				fails++;
				$display("unexpected %0t: extra read data", $time);
			end else begin
				rexp = q.pop_front();
				`CHK(rdata, rexp)
			end
		end
	end
	initial begin
		for (int p = 0; p < 8; p++) begin
			dat[p] = 8'h00;
			dir[p] = gpio_pkg::DIR_RST & gpio_pkg::PORT_MASKS[8*p +: 8];
			pul[p] = gpio_pkg::PULL_RST;
		end
		void'($urandom(14));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		ext <= {$urandom, $urandom};
		@(posedge clk);
		for (int a = 0; a < 27; a++) rd(a[7:0]);
		for (int a = 0; a < 24; a++) wr(a[7:0], 8'($urandom));
		nm <= {$urandom, $urandom};
		repeat (2) @(posedge clk);
		for (int p = 0; p < 8; p++) begin
			m = gpio_pkg::PORT_MASKS[8*p +: 8];
			`CHK(pin_out[8*p +: 8] & m, dat[p])
			`CHK(pin_oe_n[8*p +: 8] & m, dir[p])
			`CHK(pull_on[8*p +: 8] & m, pul[p] & (dir[p] | nm[8*p +: 8]))
		end
		for (int a = 0; a < 24; a++) rd(a[7:0]);
		for (int i = 0; i < 3; i++) begin
			wr(gpio_pkg::ADDR_DRIVE0, i == 0 ? 8'he4 : i == 1 ? 8'h1b : 8'($urandom));
			`CHK(drv_sel, drv)
			rd(gpio_pkg::ADDR_DRIVE0);
		end
		wr(8'h08, 8'h00);
		rd(8'h00);
		wr(8'h08, 8'hff);
		wr(gpio_pkg::ADDR_WAKEUP, 8'h08);
		fall(1'b1, 1'b1, 1);
		fall(1'b0, 1'b1, 0);
		fall(1'b1, 1'b0, 0);
		repeat (3) @(posedge clk);
		`CHK(q.size(), 0)
		stop_test();
	end
endmodule // gp_ports_tb
